// ==== verilog/sensor_operating_sequencer.sv ====
// Operating sequencer with Wishbone registers and plant I/O
`timescale 1ns/10ps
module sensor_operating_sequencer #(
  parameter int unsigned TICK_CYCLES = seq_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [seq_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // Plant pins
  input  wire logic                      start_i,
  input  wire logic                      temp_ok_i,
  input  wire logic                      malfunction_i,
  // Measurement core, same clock
  input  wire logic                      zero_done_i,
  input  wire logic                      zero_in_tol_i,
  // Drives and status lines
  output logic                           ready_o,
  output logic                           fault_o,
  output logic                           zero_gas_o,
  output logic                           pump_req_o,
  output logic                           valve_drive_o,
  output logic                           pump_drive_o,
  output logic                           fan_drive_o,
  output logic                           heater_o,
  output logic                           source_en_o,
  output logic                           selftest_o,
  output logic                           measure_o
);
  import seq_pkg::*;

  //--------------------------------------------------------------
  // Functions
  //--------------------------------------------------------------
  // Auto-zero interval in seconds
  function automatic logic [SW-1:0] ivl_secs(input logic [2:0] sel);
    logic [4:0] hours;
    hours = 5'd1;
    case (sel)
      3'd0:    hours = 5'd1;
      3'd1:    hours = 5'd2;
      3'd2:    hours = 5'd4;
      3'd3:    hours = 5'd8;
      3'd4:    hours = 5'd12;
      3'd5:    hours = 5'd16;
      default: hours = 5'd24;
    endcase
    return SW'(hours * SEC_PER_HOUR);
  endfunction : ivl_secs

  // Output levels belonging to a state
  function automatic drive_t drive_of(input state_t s);
    drive_t d;
    d          = '0;
    d.ready    = !(s inside {ST_SELFTEST, ST_HEAT, ST_STAB, ST_FAULT});
    d.zero_gas = (s == ST_ZERO);
    d.pump     = (s == ST_FLUSH) || (s == ST_ZERO);
    d.source   = !(s inside {ST_STANDBY, ST_FAULT});
    d.fan      = (s != ST_FAULT);
    d.selftest = (s == ST_SELFTEST);
    d.measure  = (s == ST_MEASURE);
    return d;
  endfunction : drive_of

  //--------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------
  logic [2:0][2:0] sync_ff;
  logic [2:0]      pin_ff;
  logic [31:0]     tick_cnt_ff;
  logic            tick;
  logic [SW-1:0]   sec_ff;
  logic [SW-1:0]   ptest_ff;
  logic [SW-1:0]   mtime_ff;
  logic [SW-1:0]   zsec_ff;
  logic [4:0]      consec_ff;
  logic [5:0]      tries_ff;
  logic [1:0]      range_ff;
  logic            zero_pend_ff;
  logic            zfail_ff;
  state_t          state_ff;
  state_t          nxt_state;
  cfg_t            cfg;
  logic [15:0]     ctrl_ff;
  drive_t          drv_ff;
  logic            heater_ff;
  logic            fault_ff;
  logic            start_s;
  logic            temp_s;
  logic            mal_s;
  logic            ptest_due;
  logic            auto_due;
  logic [SW-1:0]   stab_s;
  logic [4:0]      need;
  logic [1:0]      last_rng;
  logic            zok;
  logic            zfail;
  logic            req;
  logic [31:0]     wmask;
  logic            wb_go;

  //--------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      // Three stages, accept when stages two and three agree
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sync_ff[g] <= 3'h0;
          pin_ff[g]  <= 1'b0;
        end
        else
        begin
          sync_ff[g] <= {sync_ff[g][1:0],
                         (g == 0) ? start_i : (g == 1) ? temp_ok_i : malfunction_i};
          if (sync_ff[g][1] == sync_ff[g][2])
            pin_ff[g] <= sync_ff[g][2];
        end
      end
    end
  endgenerate

  assign start_s = pin_ff[0];
  assign temp_s  = pin_ff[1];
  assign mal_s   = pin_ff[2];

  //--------------------------------------------------------------
  // Configuration decode
  //--------------------------------------------------------------
  // Fields in struct order; the first member is the top bit of cfg
  assign cfg      = {ctrl_ff[C_EXT], ctrl_ff[C_AUTOZ], ctrl_ff[C_IVL_LSB +: 3],
                     ctrl_ff[C_STAB_LSB +: 4], ctrl_ff[C_RNG_LSB +: 2],
                     ctrl_ff[C_NEED_LSB +: 5]};
  assign stab_s   = (cfg.stab_min < 4'(STAB_MIN_MIN)) ? SW'(STAB_MIN_MIN * SEC_PER_MIN) :
                    (cfg.stab_min > 4'(STAB_MAX_MIN)) ? SW'(STAB_MAX_MIN * SEC_PER_MIN) :
                    SW'(cfg.stab_min * SEC_PER_MIN);
  assign need     = (cfg.need == 5'h0) ? 5'h1 : cfg.need;
  assign last_rng = (cfg.ranges == 2'h0) ? 2'h0 :
                    (cfg.ranges > 2'(ZERO_RANGES)) ? 2'(ZERO_RANGES - 1) :
                    cfg.ranges - 2'h1;

  //--------------------------------------------------------------
  // One-second time base
  //--------------------------------------------------------------
  // Common tick for all long durations
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tick_cnt_ff <= 32'h0000_0000;
    else if (tick)
      tick_cnt_ff <= 32'h0000_0000;
    else
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
  end

  assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

  // Seconds spent in the current state
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (nxt_state != state_ff))
      sec_ff <= '0;
    else if (tick)
      sec_ff <= sec_ff + SW'(1);
  end

  // Periodic self-test timer, halted in stand-by
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ptest_due)
      ptest_ff <= '0;
    else if (tick && (state_ff != ST_STANDBY))
      ptest_ff <= ptest_ff + SW'(1);
  end

  assign ptest_due = tick && (ptest_ff == SW'(SELFTEST_PER_S - 1)) &&
                     (state_ff != ST_STANDBY);

  // Measuring time toward the next automatic zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (state_ff == ST_ZERO))
      mtime_ff <= '0;
    else if (tick && (state_ff inside {ST_FLUSH, ST_HOLD, ST_MEASURE}) && !auto_due)
      mtime_ff <= mtime_ff + SW'(1);
  end

  assign auto_due = cfg.auto_zero && (mtime_ff >= ivl_secs(cfg.ivl_sel));

  //--------------------------------------------------------------
  // Zero adjustment bookkeeping
  //--------------------------------------------------------------
  assign zok   = zero_done_i && zero_in_tol_i && (consec_ff == need - 5'h1);
  assign zfail = (zero_done_i && !zero_in_tol_i &&
                  (tries_ff == 6'(ZERO_MAX_TRIES - 1))) ||
                 (tick && (zsec_ff == SW'(ZERO_LIMIT_S - 1)));

  // Consecutive, attempt and range counters
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (state_ff != ST_ZERO))
    begin
      consec_ff <= 5'h0;
      tries_ff  <= 6'h0;
      range_ff  <= 2'h0;
      zsec_ff   <= '0;
    end
    else
    begin
      if (tick)
        zsec_ff <= zsec_ff + SW'(1);
      if (zok)
      begin
        consec_ff <= 5'h0;
        tries_ff  <= 6'h0;
        range_ff  <= range_ff + 2'h1;
        zsec_ff   <= '0;
      end
      else if (zero_done_i && zero_in_tol_i)
        consec_ff <= consec_ff + 5'h1;
      else if (zero_done_i)
      begin
        consec_ff <= 5'h0;
        tries_ff  <= tries_ff + 6'h1;
      end
    end
  end

  // Pending zero trigger; a new trigger wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      zero_pend_ff <= 1'b0;
    else if (wb_go && wb_we_i && (wb_adr_i == ADR_CTRL) && wb_sel_i[2] &&
             wb_dat_i[C_ZSTART])
      zero_pend_ff <= 1'b1;
    else if (state_ff == ST_ZERO)
      zero_pend_ff <= 1'b0;
  end

  // Zero failure status
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      zfail_ff <= 1'b0;
    else if ((state_ff == ST_ZERO) && zfail)
      zfail_ff <= 1'b1;
  end

  //--------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------
  // Measurement wanted: internal mode, or start in external mode
  assign req = !cfg.ext_mode || start_s;

  // Next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_SELFTEST:
        if (tick && (sec_ff == SW'(SELFTEST_S - 1)))
          nxt_state = ST_HEAT;
      ST_HEAT:
        if (temp_s)
          nxt_state = ST_STAB;
      ST_STAB:
        if (tick && (sec_ff >= stab_s - SW'(1)))
          nxt_state = cfg.ext_mode ? ST_STANDBY : ST_FLUSH;
      ST_STANDBY:
        if (zero_pend_ff)
          nxt_state = ST_ZERO;
        else if (req)
          nxt_state = ST_RESUME;
      ST_RESUME:
        if (tick && (sec_ff == SW'(RESUME_S - 1)))
          nxt_state = ST_FLUSH;
      ST_FLUSH:
        if (tick && (sec_ff == SW'(FLUSH_S - 1)))
          nxt_state = ST_HOLD;
      ST_HOLD:
        if (tick && (sec_ff == SW'(HOLD_S - 1)))
          nxt_state = ST_MEASURE;
      ST_MEASURE:
        if (tick && (sec_ff == SW'(MEAS_S - 1)))
        begin
          if (zero_pend_ff || auto_due)
            nxt_state = ST_ZERO;
          else if (!req)
            nxt_state = ST_STANDBY;
          else
            nxt_state = ST_FLUSH;
        end
      ST_ZERO:
        if (zfail)
          nxt_state = ST_FAULT;
        else if (zok && (range_ff == last_rng))
          nxt_state = (req || cfg.auto_zero) ? ST_FLUSH : ST_STANDBY;
      ST_FAULT:
        nxt_state = ST_FAULT;
      default:
        nxt_state = ST_FAULT;
    endcase
    if ((state_ff != ST_FAULT) && mal_s &&
        ((state_ff == ST_SELFTEST) || ptest_due))
      nxt_state = ST_FAULT;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_ff <= ST_SELFTEST;
    else
      state_ff <= nxt_state;
  end

  //--------------------------------------------------------------
  // Output registers
  //--------------------------------------------------------------
  // Drives follow the next state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      drv_ff    <= drive_of(ST_SELFTEST);
      heater_ff <= 1'b0;
      fault_ff  <= 1'b0;
    end
    else
    begin
      drv_ff    <= drive_of(nxt_state);
      heater_ff <= !temp_s && (nxt_state != ST_FAULT);
      fault_ff  <= (nxt_state == ST_FAULT);
    end
  end

  assign ready_o       = drv_ff.ready;
  assign fault_o       = fault_ff;
  assign zero_gas_o    = drv_ff.zero_gas;
  assign valve_drive_o = drv_ff.zero_gas;
  assign pump_req_o    = drv_ff.pump;
  assign pump_drive_o  = drv_ff.pump;
  assign fan_drive_o   = drv_ff.fan;
  assign heater_o      = heater_ff;
  assign source_en_o   = drv_ff.source;
  assign selftest_o    = drv_ff.selftest;
  assign measure_o     = drv_ff.measure;

  //--------------------------------------------------------------
  // Wishbone register slave
  //--------------------------------------------------------------
  assign wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & CTRL_MASK;

  // Control register write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_ff <= CTRL_RESET;
    else if (wb_go && wb_we_i && (wb_adr_i == ADR_CTRL))
      ctrl_ff <= (ctrl_ff & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
  end

  // One-cycle acknowledge and read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_go;
      wb_dat_o <= 32'h0000_0000;
      if (wb_go && !wb_we_i)
        case (wb_adr_i)
          ADR_CTRL:   wb_dat_o <= {16'h0000, ctrl_ff};
          ADR_STATUS: wb_dat_o <= (32'(state_ff) |
                                   (32'(drv_ff.ready) << S_READY) |
                                   (32'(fault_ff) << S_FAULT) |
                                   (32'(zfail_ff) << S_ZFAIL) |
                                   (32'(tries_ff) << S_TRY_LSB));
          ADR_MTIME:  wb_dat_o <= 32'(mtime_ff);
          default:    wb_dat_o <= 32'h0000_0000;
        endcase
    end
  end
endmodule : sensor_operating_sequencer

// ==== verilog/seq_pkg.sv ====
// Constants, types and register map of the operating sequencer
package seq_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned SEC_PER_MIN    = 60;
  localparam int unsigned SEC_PER_HOUR   = 3600;
  // Durations in seconds or minutes, zero-cycle limits and timer width
  localparam int unsigned SELFTEST_S     = 5;
  localparam int unsigned SELFTEST_PER_S = 60;
  localparam int unsigned RESUME_S       = 30;
  localparam int unsigned FLUSH_S        = 5;
  localparam int unsigned HOLD_S         = 3;
  localparam int unsigned MEAS_S         = 10;
  localparam int unsigned STAB_MIN_MIN   = 2;
  localparam int unsigned STAB_MAX_MIN   = 15;
  localparam int unsigned ZERO_LIMIT_MIN = 15;
  localparam int unsigned ZERO_LIMIT_S   = ZERO_LIMIT_MIN * SEC_PER_MIN;
  localparam int unsigned ZERO_MAX_TRIES = 50;
  localparam int unsigned ZERO_RANGES    = 3;
  localparam int unsigned SW             = 17;
  // Register map, byte addresses
  localparam int unsigned ADR_W          = 8;
  localparam logic [7:0]  ADR_CTRL       = 8'h00;
  localparam logic [7:0]  ADR_STATUS     = 8'h04;
  localparam logic [7:0]  ADR_MTIME      = 8'h08;
  // Control register fields
  localparam int unsigned C_EXT          = 0;
  localparam int unsigned C_AUTOZ        = 1;
  localparam int unsigned C_IVL_LSB      = 2;
  localparam int unsigned C_STAB_LSB     = 5;
  localparam int unsigned C_RNG_LSB      = 9;
  localparam int unsigned C_NEED_LSB     = 11;
  localparam int unsigned C_ZSTART       = 16;
  localparam logic [31:0] CTRL_MASK      = 32'h0000_FFFF;
  localparam logic [15:0] CTRL_RESET     = 16'h2048;
  // Status register fields
  localparam int unsigned S_READY        = 4;
  localparam int unsigned S_FAULT        = 5;
  localparam int unsigned S_ZFAIL        = 6;
  localparam int unsigned S_TRY_LSB      = 8;

  typedef enum logic [3:0] {
    ST_SELFTEST, ST_HEAT, ST_STAB, ST_STANDBY, ST_RESUME,
    ST_FLUSH, ST_HOLD, ST_MEASURE, ST_ZERO, ST_FAULT
  } state_t;

  typedef struct packed {
    logic       ext_mode;
    logic       auto_zero;
    logic [2:0] ivl_sel;
    logic [3:0] stab_min;
    logic [1:0] ranges;
    logic [4:0] need;
  } cfg_t;

  typedef struct packed {
    logic ready;
    logic zero_gas;
    logic pump;
    logic source;
    logic fan;
    logic selftest;
    logic measure;
  } drive_t;
endpackage : seq_pkg

// ==== test/sos_checker_sva.sv ====
// Port-level assertions for the operating sequencer
`timescale 1ns/10ps
module sos_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Register bus handshake
  input  wire logic wb_cyc_i,
  input  wire logic wb_stb_i,
  input  wire logic wb_ack_o,
  // Drives and status lines
  input  wire logic ready_o,
  input  wire logic fault_o,
  input  wire logic zero_gas_o,
  input  wire logic pump_req_o,
  input  wire logic valve_drive_o,
  input  wire logic pump_drive_o,
  input  wire logic source_en_o,
  input  wire logic selftest_o,
  input  wire logic measure_o
);
  localparam longint unsigned RES_LO = 29 * longint'(TICK_CYCLES);
  localparam longint unsigned RES_HI = 31 * longint'(TICK_CYCLES);
  logic [39:0] since_sb_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Helper logic and sequences
  // ----------------------------------------
  // Cycles since stand-by was last left
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ready_o && !source_en_o))
      since_sb_ff <= 40'h00_0000_0000;
    else if (since_sb_ff != 40'hFF_FFFF_FFFF)
      since_sb_ff <= since_sb_ff + 40'h00_0000_0001;
  end
  sequence boot_s;
    $fell(rst_i);
  endsequence
  sequence flush_after_sb_s;
    $rose(pump_req_o) && !zero_gas_o && (since_sb_ff < RES_HI);
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  boot_state_a: assert property (boot_s |-> selftest_o && !ready_o && !fault_o)
    else $error("outputs after reset release wrong");
  ready_startup_a: assert property (selftest_o |-> !ready_o)
    else $error("ready high during self-test");
  fault_sticky_a: assert property (fault_o |=> fault_o)
    else $error("fault dropped without reset");
  fault_quiet_a: assert property (fault_o |-> !ready_o && !source_en_o && !measure_o)
    else $error("activity while faulted");
  cell_closed_a: assert property (measure_o |-> !pump_req_o && !pump_drive_o)
    else $error("pump on while cell closed");
  zero_valve_a: assert property (zero_gas_o |-> valve_drive_o && pump_req_o && !measure_o)
    else $error("zero gas path wrong");
  pump_lines_a: assert property (pump_req_o == pump_drive_o)
    else $error("pump request and drive differ");
  standby_off_a: assert property (ready_o && !source_en_o |-> !pump_drive_o && !measure_o)
    else $error("stand-by left a load on");
  resume_wait_a: assert property (flush_after_sb_s |-> since_sb_ff >= RES_LO)
    else $error("flush too early after stand-by");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
endmodule : sos_checker

bind sensor_operating_sequencer sos_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ready_o, .fault_o, .zero_gas_o,
  .pump_req_o, .valve_drive_o, .pump_drive_o, .source_en_o, .selftest_o, .measure_o
);

// ==== test/plant_model.sv ====
// Plant stand-in: chamber heating and zero-cycle results
`timescale 1ns/10ps
module plant_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Device drives seen by the plant
  input  wire logic        heater_i,
  input  wire logic        zero_gas_i,
  // Tolerance outcome per zero cycle, first cycle in bit 0
  input  wire logic [63:0] tol_seq_i,
  // Plant responses
  output logic             temp_ok_o = 1'b0,
  output logic             zero_done_o = 1'b0,
  output logic             zero_in_tol_o = 1'b0,
  output logic [6:0]       pulses_o = 7'h00
);
  logic [5:0] heat_ff = 6'h00;
  logic [2:0] div_ff  = 3'h0;

  // Threshold reached only after a fixed time of heating
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      heat_ff   <= 6'h00;
      temp_ok_o <= 1'b0;
    end
    else if (heater_i && !temp_ok_o)
    begin
      heat_ff   <= heat_ff + 6'h01;
      temp_ok_o <= (heat_ff == 6'h27);
    end
  end

  // One zero result every eight cycles while zero gas flows
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_ff        <= 3'h0;
      pulses_o      <= 7'h00;
      zero_done_o   <= 1'b0;
      zero_in_tol_o <= 1'b0;
    end
    else if (!zero_gas_i)
    begin
      div_ff        <= 3'h0;
      zero_done_o   <= 1'b0;
      zero_in_tol_o <= ~zero_in_tol_o; // Meaningless between results
    end
    else
    begin
      div_ff        <= div_ff + 3'h1;
      zero_done_o   <= (div_ff == 3'h7);
      zero_in_tol_o <= (div_ff == 3'h7) ? tol_seq_i[pulses_o[5:0]] : ~zero_in_tol_o;
      if (div_ff == 3'h7)
        pulses_o <= pulses_o + 7'h01;
    end
  end
endmodule : plant_model

// ==== test/sensor_operating_sequencer_tb.sv ====
// Directed bench for the operating sequencer
`timescale 1ns/10ps
module sensor_operating_sequencer_tb;
  import seq_pkg::*;
  localparam int unsigned TICK = 4;
  // Bench stimulus
  logic        clk_i         = 1'b0;
  logic        rst_i         = 1'b1;
  logic        wb_cyc_i      = 1'b0;
  logic        wb_stb_i      = 1'b0;
  logic        wb_we_i       = 1'b0;
  logic [7:0]  wb_adr_i      = 8'h00;
  logic [3:0]  wb_sel_i      = 4'h0;
  logic [31:0] wb_dat_i      = 32'h0000_0000;
  logic        start_i       = 1'b0;
  logic        malfunction_i = 1'b0;
  logic [63:0] tol_seq       = 64'h0000_0000_0000_00F7;
  // Model and design outputs
  logic        temp_ok_i, zero_done_i, zero_in_tol_i, wb_ack_o, ready_o, fault_o;
  logic        zero_gas_o, pump_req_o, valve_drive_o, pump_drive_o, fan_drive_o;
  logic        heater_o, source_en_o, selftest_o, measure_o;
  logic [6:0]  pulses;
  logic [31:0] wb_dat_o;
  // Bookkeeping
  int          n_fail          = 0;
  int          samples_checked = 0;
  int          cyc_n           = 0;
  int          n;

  sensor_operating_sequencer #(.TICK_CYCLES(TICK)) dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .start_i, .temp_ok_i, .malfunction_i, .zero_done_i,
    .zero_in_tol_i, .ready_o, .fault_o, .zero_gas_o, .pump_req_o, .valve_drive_o,
    .pump_drive_o, .fan_drive_o, .heater_o, .source_en_o, .selftest_o, .measure_o
  );
  plant_model plant (
    .clk_i, .rst_i, .heater_i(heater_o), .zero_gas_i(zero_gas_o), .tol_seq_i(tol_seq),
    .temp_ok_o(temp_ok_i), .zero_done_o(zero_done_i), .zero_in_tol_o(zero_in_tol_i),
    .pulses_o(pulses)
  );

  // ----------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------
  always #2.5 clk_i = ~clk_i;
  // Cut a hung run short
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 25000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled high
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    chk("ack", 32'h0000_0001, {31'h0000_0000, wb_ack_o});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_io
  task automatic wb_rd(input string name, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_io(1'b0, a, 32'h0000_0000, q);
    chk(name, e, q);
  endtask : wb_rd
  task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_io(1'b1, a, d, q);
  endtask : wb_wr
  function automatic logic pick(input int sel);
    case (sel)
      0: return pump_req_o;
      1: return zero_gas_o;
      2: return measure_o;
      3: return ready_o & ~source_en_o;
      4: return fault_o;
      5: return ready_o;
      6: return temp_ok_i;
      default: return ~zero_gas_o;
    endcase
  endfunction : pick
  // Bounded wait; cycles waited come back in k
  task automatic wait_on(input int sel, input int lim, output int k);
    k = 0;
    while (pick(sel) !== 1'b1 && k < lim)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("wait", 32'h0000_0001, {31'h0000_0000, pick(sel)});
  endtask : wait_on
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : do_reset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    do_reset();
    chk("selftest", 1, selftest_o & fan_drive_o);
    chk("heater", 1, heater_o);
    wb_rd("status", ADR_STATUS, 32'h0000_0000);
    wb_rd("ctrl", ADR_CTRL, 32'h0000_2048);
    wb_rd("unmapped", 8'h0C, 32'h0000_0000);
    wb_wr(ADR_CTRL, 32'h0001_2048);
    wb_rd("ctrl_trig", ADR_CTRL, 32'h0000_2048);
    wait_on(6, 300, n);
    wait_on(5, 800, n);
    chk("stab_len", 1, (n >= 119 * TICK) && (n <= 120 * TICK + 10));
    chk("flush_pump", 1, pump_req_o & pump_drive_o & ~zero_gas_o);
    wait_on(2, 100, n);
    chk("cell_pump", 0, pump_req_o);
    wait_on(1, 200, n);
    chk("zero_valve", 1, valve_drive_o & zero_gas_o & pump_drive_o);
    wb_wr(ADR_CTRL, 32'h0000_2049);
    wait_on(7, 400, n);
    chk("zero_cycles", 8, pulses);
    wait_on(3, 50, n);
    chk("standby_off", 0, source_en_o | pump_drive_o | measure_o);
    wb_rd("status_sb", ADR_STATUS, 32'h0000_0013);
    wb_rd("mtime", ADR_MTIME, 32'h0000_0000);
    repeat (200) @(posedge clk_i);
    chk("no_request", 1, ready_o & ~source_en_o);
    start_i <= 1'b1;
    wait_on(0, 200, n);
    chk("resume_len", 1, (n >= 29 * TICK) && (n <= 30 * TICK + 8));
    start_i <= 1'b0;
    tol_seq <= 64'h0000_0000_0000_0000;
    do_reset();
    wb_wr(ADR_CTRL, 32'h0001_2048);
    wait_on(1, 1200, n);
    wait_on(4, 600, n);
    chk("fail_tries", 50, pulses);
    repeat (20) @(posedge clk_i);
    chk("fault_held", 1, fault_o & ~ready_o & ~fan_drive_o);
    wb_rd("status_fail", ADR_STATUS, 32'h0000_0069);
    // Automatic zero after one hour of measuring, two ranges
    do_reset();
    tol_seq <= 64'hFFFF_FFFF_FFFF_FFFF;
    wb_wr(ADR_CTRL, 32'h0000_2442);
    wait_on(1, 17000, n);
    chk("auto_ivl", 1, n >= 3600 * TICK);
    wait_on(7, 150, n);
    chk("two_ranges", 8, pulses);
    chk("auto_back", 1, pump_req_o & source_en_o & ready_o);
    do_reset();
    malfunction_i <= 1'b1;
    wait_on(4, 20, n);
    malfunction_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("fault_sticky", 1, fault_o & ~ready_o);
    report_and_stop();
  end
endmodule : sensor_operating_sequencer_tb
